// ### hdl/sbs_if.sv
// pin bundle between the sram and its controller
`timescale 1ns/1ns
`default_nettype none
interface sbs_if;
   import sbs_pkg::*;
   logic              chip_select_n;
   logic              proc_addr_strobe_n;
   logic              ctrl_addr_strobe_n;
   logic              burst_advance_n;
   logic              global_write_n;
   logic              byte_write_gate_n;
   logic [LANES-1:0]  lane_write_en_n;
   logic              out_enable_n;
   logic              linear_order_sel_n;
   logic              flowthrough_sel_n;
   logic              deselect_mode_sel;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_host;
   logic [LANES-1:0]  dq_host_oe;
   logic [DATA_W-1:0] dq_dev;
   logic [LANES-1:0]  dq_dev_oe;
   logic [DATA_W-1:0] dq;
   // lane level: device wins, then host; an undriven lane shows the host word inverted
   // so that a missing driver can never pass for the host's own word
   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         dq[l*LANE_W +: LANE_W] = dq_dev_oe[l]  ? dq_dev[l*LANE_W +: LANE_W]  :
                                  dq_host_oe[l] ? dq_host[l*LANE_W +: LANE_W] :
                                                  ~dq_host[l*LANE_W +: LANE_W];
      end
   end
   modport dev (input chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
                burst_advance_n, global_write_n, byte_write_gate_n, lane_write_en_n,
                out_enable_n, linear_order_sel_n, flowthrough_sel_n, deselect_mode_sel,
                addr, dq, output dq_dev, dq_dev_oe);
   modport ctl (output chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
                burst_advance_n, global_write_n, byte_write_gate_n, lane_write_en_n,
                out_enable_n, linear_order_sel_n, flowthrough_sel_n, deselect_mode_sel,
                addr, dq_host, dq_host_oe, input dq);
endinterface
`default_nettype wire

// ### hdl/sbs_pkg.sv
// shared constants and types for the burst sram command decode pair
// Notes on behaviour
// - reads drive every lane whatever the enables
// - byte gate low writes only enabled lanes
// - data lanes stay undriven during every write
// - lanes three and four exist only wide
// - select high, ctrl strobe low deselects
// - proc strobe or non-write ctrl strobe reads
// - ctrl strobe with write begins write burst
// - no strobe, advance low reads next address
// - no strobe, advance low writes next address
// - no strobe, advance high rereads current address
// - no strobe, advance high writes current address
// - output enable gates drivers asynchronously
// - controller may hold strobes for single accesses
// - controller may burst with ctrl strobe only
// - dummy reads advance counter like reads
// - hold output enable high before writes
// - global write low writes all lanes
// - two-bit counter, linear or xor order
// - flow-through bypasses the output register
// - deselect mode picks single or dual cycle
package sbs_pkg;
   localparam int ADDR_W = 10;
   localparam int LANE_W = 9;
   localparam int LANES  = 4;
   localparam int DATA_W = LANE_W * LANES;
   localparam int CNT_W  = 2;
   localparam int HI_W   = DATA_W - 32;
   localparam bit WIDE_CFG = 1'b1;
   localparam logic [LANES-1:0] LANE_MASK = WIDE_CFG ? 4'hF : 4'h3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 2'h1;
   localparam logic [1:0] FT_LAT   = 2'h1;
   localparam logic [1:0] PIPE_LAT = 2'h2;
   // apb map of the controller
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] SBS_CFG_OFS   = 8'h00;
   localparam logic [APB_AW-1:0] SBS_ADDR_OFS  = 8'h04;
   localparam logic [APB_AW-1:0] SBS_WDATA_OFS = 8'h08;
   localparam logic [APB_AW-1:0] SBS_HI_OFS    = 8'h0C;
   localparam logic [APB_AW-1:0] SBS_RDATA_OFS = 8'h10;
   localparam logic [APB_AW-1:0] SBS_CMD_OFS   = 8'h14;
   localparam logic [APB_AW-1:0] SBS_STAT_OFS  = 8'h18;
   localparam int CFG_W       = 3;
   localparam int CFG_FT_BIT  = 0;
   localparam int CFG_LBO_BIT = 1;
   localparam int CFG_SCD_BIT = 2;
   localparam logic [CFG_W-1:0] CFG_RST = 3'h7;
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_LANE_LSB = 2;
   localparam int CMD_GW_BIT   = 6;
   localparam int CMD_CONT_BIT = 7;
   localparam int CMD_HOLD_BIT = 8;
   typedef enum logic [2:0] {SBS_DESEL, SBS_RD_BEGIN, SBS_WR_BEGIN, SBS_RD_CONT,
                             SBS_WR_CONT, SBS_RD_HOLD, SBS_WR_HOLD} sbs_cycle_t;
   typedef enum logic [1:0] {SBS_OP_READ, SBS_OP_WRITE, SBS_OP_DUMMY, SBS_OP_DESEL} sbs_op_t;
   typedef enum logic [1:0] {SBS_H_IDLE, SBS_H_ISSUE, SBS_H_WAIT} sbs_hstate_t;
endpackage

// ### hdl/sbs_sram_ctl.sv
// controller end: apb registers turned into sram bus cycles
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sbs_sram_ctl
   import sbs_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [APB_AW-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic [31:0]            o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   sbs_if.ctl                     bus
);

   sbs_hstate_t       st, next_st;
   logic [CFG_W-1:0]  cfg, next_cfg;
   logic [ADDR_W-1:0] addr_r, next_addr_r;
   logic [DATA_W-1:0] wdata, next_wdata;
   logic [DATA_W-1:0] rdata, next_rdata;
   logic [31:0]       prdata, next_prdata;
   sbs_op_t           op, next_op;
   logic [LANES-1:0]  lanes, next_lanes;
   logic              gw, next_gw;
   logic              cont, next_cont;
   logic              hold, next_hold;
   logic [1:0]        wcnt, next_wcnt;
   // registered pins
   logic cs_n, next_cs_n, ctrl_addr_strobe_n_n, next_ctrl_addr_strobe_n_n, adv_n, next_adv_n;
   logic gw_n, next_gw_n, bw_n, next_bw_n, oe_n, next_oe_n, dqoe, next_dqoe;
   logic [LANES-1:0]  lane_n, next_lane_n;
   logic              wr_acc;

   assign wr_acc = i_psel && i_penable && i_pwrite;

   // apb decode, sequencing and pin planning
   always_comb begin
      next_st = st; next_cfg = cfg; next_addr_r = addr_r; next_wdata = wdata;
      next_rdata = rdata; next_prdata = prdata; next_op = op; next_lanes = lanes;
      next_gw = gw; next_cont = cont; next_hold = hold; next_wcnt = wcnt;
      next_cs_n = cs_n; next_ctrl_addr_strobe_n_n = ctrl_addr_strobe_n_n; next_adv_n = adv_n; next_gw_n = gw_n;
      next_bw_n = bw_n; next_oe_n = oe_n; next_dqoe = dqoe; next_lane_n = lane_n;
      // read data is latched in the setup cycle so the access cycle answers at once
      if (i_psel && !i_penable) begin
         unique case (i_paddr)
            SBS_CFG_OFS:   next_prdata = 32'(cfg);
            SBS_ADDR_OFS:  next_prdata = 32'(addr_r);
            SBS_WDATA_OFS: next_prdata = wdata[31:0];
            SBS_HI_OFS:    next_prdata = 32'(rdata[DATA_W-1:32]);
            SBS_RDATA_OFS: next_prdata = rdata[31:0];
            SBS_STAT_OFS:  next_prdata = 32'(st != SBS_H_IDLE);
            default:       next_prdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         unique case (i_paddr)
            SBS_CFG_OFS:   next_cfg = i_pwdata[CFG_W-1:0];
            SBS_ADDR_OFS:  next_addr_r = i_pwdata[ADDR_W-1:0];
            SBS_WDATA_OFS: next_wdata[31:0] = i_pwdata;
            SBS_HI_OFS:    next_wdata[DATA_W-1:32] = i_pwdata[HI_W-1:0];
            default: ;
         endcase
      end
      unique case (st)
         SBS_H_IDLE: begin
            // a command while busy is dropped
            if (wr_acc && i_paddr == SBS_CMD_OFS) begin
               next_op    = sbs_op_t'(i_pwdata[CMD_OP_LSB +: 2]);
               next_lanes = i_pwdata[CMD_LANE_LSB +: LANES];
               next_gw    = i_pwdata[CMD_GW_BIT];
               next_cont  = i_pwdata[CMD_CONT_BIT];
               next_hold  = i_pwdata[CMD_HOLD_BIT];
               next_st    = SBS_H_ISSUE;
               // ctrl strobe loads, advance low continues
               next_cs_n   = (next_op == SBS_OP_DESEL);
               next_ctrl_addr_strobe_n_n = (next_op != SBS_OP_DESEL) && (next_cont || next_hold);
               next_adv_n  = next_hold;
               next_gw_n   = !((next_op == SBS_OP_WRITE) && next_gw);
               next_bw_n   = !((next_op == SBS_OP_WRITE) && !next_gw);
               next_lane_n = ~next_lanes;
               next_dqoe   = (next_op == SBS_OP_WRITE);
               // enable stays high across write issue
               next_oe_n   = 1'b1;
            end
         end
         SBS_H_ISSUE: begin
            next_dqoe = 1'b0; next_gw_n = 1'b1; next_bw_n = 1'b1;
            if (op == SBS_OP_READ || op == SBS_OP_DUMMY) begin
               // suspend read keeps the location while data is awaited
               next_cs_n = 1'b1; next_ctrl_addr_strobe_n_n = 1'b1; next_adv_n = 1'b1;
               next_oe_n = (op == SBS_OP_DUMMY);
               next_wcnt = cfg[CFG_FT_BIT] ? PIPE_LAT : FT_LAT;
               next_st   = SBS_H_WAIT;
            end else begin
               next_cs_n = 1'b1; next_ctrl_addr_strobe_n_n = 1'b0; next_adv_n = 1'b1;
               next_st   = SBS_H_IDLE;
            end
         end
         SBS_H_WAIT: begin
            if (wcnt == FT_LAT) begin
               if (op == SBS_OP_READ) next_rdata = bus.dq;
               // back to deselect; enable high again
               next_cs_n = 1'b1; next_ctrl_addr_strobe_n_n = 1'b0; next_oe_n = 1'b1;
               next_st   = SBS_H_IDLE;
            end else begin
               next_wcnt = wcnt - FT_LAT;
            end
         end
         default: next_st = SBS_H_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= SBS_H_IDLE; cfg <= CFG_RST; addr_r <= {ADDR_W{1'b0}};
         wdata <= {DATA_W{1'b0}}; rdata <= {DATA_W{1'b0}}; prdata <= 32'h0000_0000;
         op <= SBS_OP_READ; lanes <= {LANES{1'b0}}; gw <= 1'b0; cont <= 1'b0;
         hold <= 1'b0; wcnt <= 2'h0; cs_n <= 1'b1; ctrl_addr_strobe_n_n <= 1'b0; adv_n <= 1'b1;
         gw_n <= 1'b1; bw_n <= 1'b1; oe_n <= 1'b1; dqoe <= 1'b0;
         lane_n <= {LANES{1'b1}};
      end else begin
         st <= next_st; cfg <= next_cfg; addr_r <= next_addr_r; wdata <= next_wdata;
         rdata <= next_rdata; prdata <= next_prdata; op <= next_op; lanes <= next_lanes;
         gw <= next_gw; cont <= next_cont; hold <= next_hold; wcnt <= next_wcnt;
         cs_n <= next_cs_n; ctrl_addr_strobe_n_n <= next_ctrl_addr_strobe_n_n; adv_n <= next_adv_n; gw_n <= next_gw_n;
         bw_n <= next_bw_n; oe_n <= next_oe_n; dqoe <= next_dqoe; lane_n <= next_lane_n;
      end
   end

   assign o_prdata  = prdata;
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;
   // processor strobe held high for ctrl-strobe cycles
   assign bus.proc_addr_strobe_n = 1'b1;
   assign bus.chip_select_n      = cs_n;
   assign bus.ctrl_addr_strobe_n = ctrl_addr_strobe_n_n;
   assign bus.burst_advance_n    = adv_n;
   assign bus.global_write_n     = gw_n;
   assign bus.byte_write_gate_n  = bw_n;
   assign bus.lane_write_en_n    = lane_n;
   assign bus.out_enable_n       = oe_n;
   assign bus.flowthrough_sel_n  = cfg[CFG_FT_BIT];
   assign bus.linear_order_sel_n = cfg[CFG_LBO_BIT];
   assign bus.deselect_mode_sel  = cfg[CFG_SCD_BIT];
   assign bus.addr               = addr_r;
   assign bus.dq_host            = wdata;
   assign bus.dq_host_oe         = {LANES{dqoe}};

endmodule
`default_nettype wire

// ### hdl/sbs_sram_dev.sv
// synchronous burst sram end: command decode, burst counter, byte writes, output stage
`timescale 1ns/1ns
`default_nettype none
module sbs_sram_dev
   import sbs_pkg::*;
(
   input  wire logic     i_sys_clk,
   input  wire logic     i_rst,
   sbs_if.dev            bus,
   output var sbs_cycle_t o_cycle_kind,
   output logic          o_drive
);

   // storage array, one word per address
   logic [DATA_W-1:0] mem [2**ADDR_W];

   // burst state
   logic [ADDR_W-1:CNT_W] base;
   logic [ADDR_W-1:CNT_W] next_base;
   logic [CNT_W-1:0]      start;
   logic [CNT_W-1:0]      next_start;
   logic [CNT_W-1:0]      cnt;
   logic [CNT_W-1:0]      next_cnt;

   // output stage state
   logic [DATA_W-1:0]     rd1;
   logic [DATA_W-1:0]     next_rd1;
   logic [DATA_W-1:0]     rd2;
   logic [DATA_W-1:0]     next_rd2;
   logic                  drv1;
   logic                  next_drv1;
   logic                  drv2;
   logic                  next_drv2;
   logic                  wr_q;
   logic                  next_wr_q;
   sbs_cycle_t            cyc_q;

   // decoded cycle
   sbs_cycle_t            cyc;
   logic [LANES-1:0]      lane_wr;
   logic                  wr_req;
   logic                  is_read;
   logic                  is_write;
   logic [ADDR_W-1:0]     acc_addr;
   logic                  lin_order;
   logic                  flow_mode;
   logic                  single_desel;

   // mode pins are static straps, read directly
   assign lin_order    = !bus.linear_order_sel_n;
   assign flow_mode    = !bus.flowthrough_sel_n;
   assign single_desel = bus.deselect_mode_sel;

   // low address bits of a burst step
   function automatic logic [CNT_W-1:0] burst_lo(input logic [CNT_W-1:0] s,
                                                 input logic [CNT_W-1:0] c,
                                                 input logic             lin);
      burst_lo = lin ? CNT_W'(s + c) : (s ^ c);
   endfunction

   // lane write mask from the global and byte write inputs
   always_comb begin
      if (!bus.global_write_n) begin
         lane_wr = LANE_MASK;
      end else if (!bus.byte_write_gate_n) begin
         // only lanes whose enable is low
         // upper lanes masked on narrow build
         lane_wr = ~bus.lane_write_en_n & LANE_MASK;
      end else begin
         lane_wr = {LANES{1'b0}};
      end
      // all enables high under the gate leaves a read
      wr_req = |lane_wr;
   end

   // synchronous command decode
   always_comb begin
      if (bus.chip_select_n && !bus.ctrl_addr_strobe_n) begin
         cyc = SBS_DESEL;
      end else if (!bus.chip_select_n && !bus.proc_addr_strobe_n) begin
         // processor strobe reads, write inputs ignored
         cyc = SBS_RD_BEGIN;
      end else if (!bus.chip_select_n && !bus.ctrl_addr_strobe_n) begin
         // ctrl strobe with write begins write
         cyc = wr_req ? SBS_WR_BEGIN : SBS_RD_BEGIN;
      end else if (!bus.burst_advance_n) begin
         cyc = wr_req ? SBS_WR_CONT : SBS_RD_CONT;
      end else begin
         cyc = wr_req ? SBS_WR_HOLD : SBS_RD_HOLD;
      end
      is_read  = (cyc == SBS_RD_BEGIN) || (cyc == SBS_RD_CONT) || (cyc == SBS_RD_HOLD);
      is_write = (cyc == SBS_WR_BEGIN) || (cyc == SBS_WR_CONT) || (cyc == SBS_WR_HOLD);
   end

   // burst counter next values and the address this edge uses
   always_comb begin
      next_base  = base;
      next_start = start;
      next_cnt   = cnt;
      unique case (cyc)
         SBS_RD_BEGIN, SBS_WR_BEGIN: begin
            next_base  = bus.addr[ADDR_W-1:CNT_W];
            next_start = bus.addr[CNT_W-1:0];
            next_cnt   = CNT_ZERO;
         end
         SBS_RD_CONT, SBS_WR_CONT: begin
            // dummy reads step like any read
            next_cnt = CNT_W'(cnt + CNT_ONE);
         end
         SBS_DESEL, SBS_RD_HOLD, SBS_WR_HOLD: begin
            next_cnt = cnt;
         end
      endcase
      // offset zero gives back the external address on a begin
      acc_addr = {next_base, burst_lo(next_start, next_cnt, lin_order)};
   end

   // read path: first stage feeds flow-through, second stage is the output register
   always_comb begin
      next_rd1  = is_read ? mem[acc_addr] : rd1;
      next_drv1 = is_read;
      // pipelined data is one stage later
      next_rd2  = rd1;
      // single-cycle deselect cuts the late stage at once
      next_drv2 = drv1 && !(single_desel && (cyc == SBS_DESEL));
      next_wr_q = is_write;
   end

   // burst and output stage registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         base  <= {(ADDR_W-CNT_W){1'b0}};
         start <= CNT_ZERO;
         cnt   <= CNT_ZERO;
         rd1   <= {DATA_W{1'b0}};
         rd2   <= {DATA_W{1'b0}};
         drv1  <= 1'b0;
         drv2  <= 1'b0;
         wr_q  <= 1'b0;
         cyc_q <= SBS_DESEL;
      end else begin
         base  <= next_base;
         start <= next_start;
         cnt   <= next_cnt;
         rd1   <= next_rd1;
         rd2   <= next_rd2;
         drv1  <= next_drv1;
         drv2  <= next_drv2;
         wr_q  <= next_wr_q;
         cyc_q <= cyc;
      end
   end

   // array write at the capture edge; no reset, contents are undefined at power up
   always_ff @(posedge i_sys_clk) begin
      if (is_write) begin
         for (int l = 0; l < LANES; l++) begin
            // enabled bytes land at the computed address
            if (lane_wr[l]) begin
               mem[acc_addr][l*LANE_W +: LANE_W] <= bus.dq[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // driver enable: a capture write or a read stage decides, then the async gate
   always_comb begin
      // a captured write turns drivers off
      o_drive = (flow_mode ? drv1 : drv2) && !wr_q;
   end

   // output enable gates drivers without the clock
   // every present lane is driven on reads
   assign bus.dq_dev_oe = {LANES{o_drive && !bus.out_enable_n}} & LANE_MASK;

   assign bus.dq_dev = flow_mode ? rd1 : rd2;

   // last decoded cycle, for observation
   assign o_cycle_kind = cyc_q;

endmodule
`default_nettype wire

// ### verification/sbs_pin_checker.sv
// concurrent checks on the pin bundle between the sram end and its controller
`timescale 1ns/1ns
`default_nettype none
module sbs_pin_checker
   import sbs_pkg::*;
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   input  wire logic             chip_select_n,
   input  wire logic             proc_addr_strobe_n,
   input  wire logic             ctrl_addr_strobe_n,
   input  wire logic             global_write_n,
   input  wire logic             byte_write_gate_n,
   input  wire logic [LANES-1:0] lane_write_en_n,
   input  wire logic             out_enable_n,
   input  wire logic             flowthrough_sel_n,
   input  wire logic [LANES-1:0] dq_host_oe,
   input  wire logic [LANES-1:0] dq_dev_oe,
   input  wire logic             deselect_mode_sel,
   input  wire logic             drive
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   logic wr;
   logic desel;
   logic rd_beg;
   logic wr_cap;
   // lanes outside the build never turn a cycle into a write
   assign wr     = !global_write_n ||
                   (!byte_write_gate_n && ((~lane_write_en_n & LANE_MASK) != 4'h0));
   assign desel  = chip_select_n && !ctrl_addr_strobe_n;
   assign rd_beg = !chip_select_n && (!proc_addr_strobe_n || (!ctrl_addr_strobe_n && !wr));
   assign wr_cap = wr && !desel && !(!chip_select_n && !proc_addr_strobe_n);
   // relations between the decoded cycle and the device drivers
   write_hiz_a: assert property (
      wr_cap |=> dq_dev_oe == 4'h0) else $error("device drives after a write");
   desel_hiz_a: assert property (
      desel [*2] |=> dq_dev_oe == 4'h0) else $error("device drives after deselect");
   scd_cut_a: assert property (
      desel && deselect_mode_sel |=> !drive) else $error("single deselect left drivers armed");
   dcd_off_a: assert property (
      desel [*2] |=> !drive) else $error("dual deselect left drivers armed");
   oe_gate_a: assert property (
      out_enable_n |-> dq_dev_oe == 4'h0) else $error("drivers on with output enable off");
   lanes_all_a: assert property (
      dq_dev_oe == 4'h0 || dq_dev_oe == LANE_MASK) else $error("partial lane drive");
   flow_lat_a: assert property (
      rd_beg && !flowthrough_sel_n ##1 !out_enable_n |-> dq_dev_oe == LANE_MASK)
      else $error("flow-through read not driven one cycle on");
   pipe_lat_a: assert property (
      rd_beg && flowthrough_sel_n && $past(desel) && $past(desel, 2) ##1 !out_enable_n
      |-> dq_dev_oe == 4'h0 ##1 (out_enable_n || dq_dev_oe == LANE_MASK))
      else $error("pipelined read latency wrong");
   oe_pre_write_a: assert property (
      wr_cap |-> out_enable_n && $past(out_enable_n)) else $error("write without oe high");
   no_fight_a: assert property (
      (dq_host_oe & dq_dev_oe) == 4'h0) else $error("both ends drive a lane");
   // main traffic kinds seen on the pins
   cover property (rd_beg && !flowthrough_sel_n);
   cover property (rd_beg && flowthrough_sel_n);
   cover property (wr_cap && global_write_n);
   cover property (desel ##1 rd_beg);
   cover property (desel && !deselect_mode_sel && drive);
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench: apb controller and sram end joined over the pin bundle
`timescale 1ns/1ns
`default_nettype none
module testbench
   import sbs_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        slverr;
   logic        drv;
   sbs_cycle_t  cyc;
   int          mismatches;
   int          tests_run;

   sbs_if sbs_if_i ();
   sbs_sram_dev sbs_sram_dev_i (.i_sys_clk(clk), .i_rst(rst), .bus(sbs_if_i),
                                .o_cycle_kind(cyc), .o_drive(drv));
   sbs_sram_ctl sbs_sram_ctl_i (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel),
                                .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
                                .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
                                .o_pslverr(slverr), .bus(sbs_if_i));
   sbs_pin_checker sbs_pin_checker_i (
      .i_sys_clk(clk), .i_rst(rst), .chip_select_n(sbs_if_i.chip_select_n),
      .proc_addr_strobe_n(sbs_if_i.proc_addr_strobe_n),
      .ctrl_addr_strobe_n(sbs_if_i.ctrl_addr_strobe_n),
      .global_write_n(sbs_if_i.global_write_n), .byte_write_gate_n(sbs_if_i.byte_write_gate_n),
      .lane_write_en_n(sbs_if_i.lane_write_en_n), .out_enable_n(sbs_if_i.out_enable_n),
      .flowthrough_sel_n(sbs_if_i.flowthrough_sel_n), .dq_host_oe(sbs_if_i.dq_host_oe),
      .dq_dev_oe(sbs_if_i.dq_dev_oe), .deselect_mode_sel(sbs_if_i.deselect_mode_sel),
      .drive(drv));

   // 10 mhz system clock
   always #50 clk = ~clk;

   function automatic logic [8:0] cmd(input logic [1:0] o, input logic [3:0] l,
                                      input logic g, input logic c, input logic h);
      return {h, c, g, l, o};
   endfunction

   // burst slot of the count c from start offset one
   function automatic logic [1:0] nx(input logic lin, input logic [1:0] c);
      return lin ? 2'h1 + c : 2'h1 ^ c;
   endfunction

   task chk(input string n, input logic [35:0] e, input logic [35:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // one apb transfer; an idle cycle follows so no strobe is driven twice in a step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      chk("pslverr", 36'h0, {35'h0, slverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // load address and data, issue a command, wait for idle, fetch read data
   task op(input logic [8:0] c, input logic [9:0] a, input logic [35:0] d,
           output logic [35:0] r);
      logic [31:0] lo;
      logic [31:0] hi;
      int i;
      apb(1'b1, SBS_ADDR_OFS, {22'h0, a}, lo);
      apb(1'b1, SBS_WDATA_OFS, d[31:0], lo);
      apb(1'b1, SBS_HI_OFS, {28'h0, d[35:32]}, lo);
      apb(1'b1, SBS_CMD_OFS, {23'h0, c}, lo);
      for (i = 0; i < 40; i++) begin
         apb(1'b0, SBS_STAT_OFS, 32'h0, lo);
         if (lo[0] === 1'b0) break;
      end
      chk("busy", 36'h0, {35'h0, lo[0]});
      apb(1'b0, SBS_RDATA_OFS, 32'h0, lo);
      apb(1'b0, SBS_HI_OFS, 32'h0, hi);
      r = {hi[3:0], lo};
   endtask

   task t_reset;
      logic [31:0] q;
      logic [35:0] r;
      chk("cycle_kind", {33'h0, SBS_DESEL}, {33'h0, cyc});
      chk("dev_oe", 36'h0, {32'h0, sbs_if_i.dq_dev_oe});
      apb(1'b0, SBS_CFG_OFS, 32'h0, q);
      chk("cfg", {33'h0, CFG_RST}, {4'h0, q});
      apb(1'b0, SBS_RDATA_OFS, 32'h0, q);
      chk("rdata", 36'h0, {4'h0, q});
      apb(1'b1, 8'h1C, 32'hFFFF_FFFF, q);
      apb(1'b0, 8'h1C, 32'h0, q);
      chk("unmapped", 36'h0, {4'h0, q});
      op(cmd(2'h3, 4'h0, 1'b0, 1'b0, 1'b0), 10'h0, 36'h0, r);
      chk("desel_oe", 36'h0, {32'h0, sbs_if_i.dq_dev_oe});
      $display("test reset done");
   endtask

   // every mode mix: global write then read back
   task t_modes;
      logic [31:0] q;
      logic [35:0] d;
      logic [35:0] r;
      int m;
      for (m = 0; m < 8; m++) begin
         apb(1'b1, SBS_CFG_OFS, 32'(m), q);
         d = 36'hA_5A5A_0F00 + 36'(m);
         op(cmd(2'h1, 4'h0, 1'b1, 1'b0, 1'b0), 10'(m * 5), d, r);
         op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), 10'(m * 5), 36'h0, r);
         chk("mode_rd", d, r);
      end
      $display("test modes done");
   endtask

   task t_lanes;
      logic [35:0] e;
      logic [35:0] r;
      int l;
      e = 36'h0;
      op(cmd(2'h1, 4'h0, 1'b1, 1'b0, 1'b0), 10'h100, e, r);
      for (l = 0; l < 4; l++) begin
         op(cmd(2'h1, 4'(1 << l), 1'b0, 1'b0, 1'b0), 10'h100, 36'hF_FFFF_FFFF, r);
         e[l*LANE_W +: LANE_W] = 9'h1FF;
         op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), 10'h100, 36'h0, r);
         chk("lane_wr", e, r);
      end
      op(cmd(2'h1, 4'h5, 1'b0, 1'b0, 1'b0), 10'h100, 36'h0, r);
      e[8:0] = 9'h0;
      e[26:18] = 9'h0;
      op(cmd(2'h1, 4'h0, 1'b0, 1'b0, 1'b0), 10'h100, 36'h0, r);
      op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), 10'h100, 36'h0, r);
      chk("lane_mix", e, r);
      $display("test lanes done");
   endtask

   // burst from offset one: continue, wrap, reread, dummy advance, suspend write
   task t_burst(input logic lin);
      logic [35:0] em [0:3];
      logic [35:0] d;
      logic [35:0] r;
      logic [31:0] q;
      int k;
      apb(1'b1, SBS_CFG_OFS, lin ? 32'h5 : 32'h7, q);
      for (k = 0; k < 5; k++) begin
         d = 36'h3_0000_0000 + 36'(lin * 16 + k);
         op(cmd(2'h1, 4'h0, 1'b1, k != 0, 1'b0), 10'h201, d, r);
         em[nx(lin, 2'(k))] = d;
      end
      for (k = 0; k < 4; k++) begin
         op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), 10'h200 + 10'(k), 36'h0, r);
         chk("burst_slot", em[k], r);
      end
      op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), 10'h201, 36'h0, r);
      op(cmd(2'h0, 4'h0, 1'b0, 1'b1, 1'b0), 10'h0, 36'h0, r);
      chk("cont_rd", em[nx(lin, 2'h1)], r);
      op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b1), 10'h0, 36'h0, r);
      chk("hold_rd", em[nx(lin, 2'h1)], r);
      op(cmd(2'h2, 4'h0, 1'b0, 1'b1, 1'b0), 10'h0, 36'h0, r);
      op(cmd(2'h0, 4'h0, 1'b0, 1'b1, 1'b0), 10'h0, 36'h0, r);
      chk("dummy_adv", em[nx(lin, 2'h3)], r);
      op(cmd(2'h1, 4'h0, 1'b1, 1'b0, 1'b1), 10'h0, 36'h0_C3C3_3C3C, r);
      op(cmd(2'h0, 4'h0, 1'b0, 1'b0, 1'b0), {8'h80, nx(lin, 2'h3)}, 36'h0, r);
      chk("hold_wr", 36'h0_C3C3_3C3C, r);
      $display("test burst done");
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence after ten reset cycles
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      mismatches = 0;
      tests_run = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_lanes();
      t_burst(1'b1);
      t_burst(1'b0);
      tally_and_finish();
   end

   // hang guard, far beyond the roughly 1400 cycles the tests need
   initial begin
      #3000000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule
`default_nettype wire
